// ### hdl/alr_top.sv
// Ambient light readout: conversion sequencer, thresholds, alert, I2C target, AHB-Lite registers.
// Assumes channel step counts come from the converter on core_clk; SCL, SDA and the alert
// wire are asynchronous pins resolved outside as open-drain lines.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module alr_top
    import alr_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DOC,
    parameter logic [6:0] I2C_ADDR = 7'h39
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [9:0] broadband_channel_count,
    input wire logic [9:0] infrared_channel_count,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic alert_i,
    output logic alert_o,
    output logic alert_oe,
    output logic irq
);
    typedef struct packed {
        alr_conv_t conv;
        logic [11:0] steps;
        logic [15:0] acc_bb;
        logic [15:0] acc_ir;
        logic [15:0] data_bb;
        logic [15:0] data_ir;
        logic [CTRL_W-1:0] ctrl;
        logic [15:0] timing;
        logic [15:0] th_low;
        logic [15:0] th_high;
        logic [3:0] persist;
        logic [3:0] pcount;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [7:0] ahb_addr;
        logic ahb_write;
        logic ahb_read;
        logic [31:0] hrdata;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] alert_s;
        alr_i2c_t i2c;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rnw;
        logic nack;
        logic first_byte;
        logic [1:0] ptr;
        logic sda_low;
    } alr_state_t;

    alr_state_t r;
    alr_state_t n;

    logic step_tick;
    logic [15:0] bb_sum;
    logic [15:0] ir_sum;
    logic oor;
    logic trig;
    logic cyc_done;
    logic accept;
    logic i2c_clear;
    logic [IRQ_W-1:0] w1c;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;

    function automatic logic [15:0] sat_add(input logic [15:0] acc, input logic [9:0] inc);
        logic [16:0] s;
        s = {1'b0, acc} + {7'h00, inc};
        return s[16] ? 16'hffff : s[15:0];
    endfunction : sat_add

    function automatic logic [7:0] result_byte(input logic [1:0] sel, input logic [15:0] bb,
                                               input logic [15:0] ir);
        case (sel)
            2'h0: return bb[7:0];
            2'h1: return bb[15:8];
            2'h2: return ir[7:0];
            default: return ir[15:8];
        endcase
    endfunction : result_byte

    alr_step_timer #(
        .COUNT(STEP_CYCLES)
    ) u_step (
        .core_clk(core_clk),
        .rst(rst),
        .run(r.conv != CV_IDLE),
        .tick(step_tick)
    );

    assign bb_sum = sat_add(r.acc_bb, broadband_channel_count);
    assign ir_sum = sat_add(r.acc_ir, infrared_channel_count);
    assign oor = (bb_sum > r.th_high) || (bb_sum < r.th_low);
    assign trig = oor && (r.persist == 4'h0 || ({1'b0, r.pcount} + 5'h01) >= {1'b0, r.persist});
    assign cyc_done = r.conv == CV_INTEG && r.ctrl[CTRL_RUN_BIT] && step_tick && r.steps == 12'h001;
    assign accept = hsel && hready && htrans[1];
    assign scl_rise = r.scl_s[1] && !r.scl_s[2];
    assign scl_fall = !r.scl_s[1] && r.scl_s[2];
    assign i2c_start = r.scl_s[1] && r.scl_s[2] && !r.sda_s[1] && r.sda_s[2];
    assign i2c_stop = r.scl_s[1] && r.scl_s[2] && r.sda_s[1] && !r.sda_s[2];

    always_comb begin
        n = r;
        i2c_clear = 1'b0;
        w1c = '0;
        // Pin synchronisers; only the second stage onward feeds logic
        n.scl_s = {r.scl_s[1:0], scl_i};
        n.sda_s = {r.sda_s[1:0], sda_i};
        n.alert_s = {r.alert_s[0], alert_i};

        // Conversion sequencer
        case (r.conv)
            CV_IDLE: begin
                if (r.ctrl[CTRL_RUN_BIT]) begin
                    n.conv = CV_INTEG;
                    n.steps = STEPS_FULL - {4'h0, r.timing[7:0]};
                    n.acc_bb = '0;
                    n.acc_ir = '0;
                end
            end
            CV_INTEG: begin
                if (!r.ctrl[CTRL_RUN_BIT]) begin
                    n.conv = CV_IDLE;
                end else if (step_tick) begin
                    n.acc_bb = bb_sum;
                    n.acc_ir = ir_sum;
                    n.steps = r.steps - 12'h001;
                    if (r.steps == 12'h001) begin
                        n.data_bb = bb_sum;
                        n.data_ir = ir_sum;
                        n.acc_bb = '0;
                        n.acc_ir = '0;
                        n.pcount = !oor ? 4'h0 : (r.pcount == 4'hf ? 4'hf : r.pcount + 4'h1);
                        if (r.ctrl[CTRL_WAIT_EN_BIT]) begin
                            n.conv = CV_WAIT;
                            n.steps = 12'((STEPS_FULL - {4'h0, r.timing[15:8]})
                                * (r.ctrl[CTRL_WAIT_LONG_BIT] ? WAIT_LONG_FACTOR : 12'h001));
                        end else begin
                            n.steps = STEPS_FULL - {4'h0, r.timing[7:0]};
                        end
                    end
                end
            end
            CV_WAIT: begin
                if (!r.ctrl[CTRL_RUN_BIT]) begin
                    n.conv = CV_IDLE;
                end else if (step_tick) begin
                    n.steps = r.steps - 12'h001;
                    if (r.steps == 12'h001) begin
                        n.conv = CV_INTEG;
                        n.steps = STEPS_FULL - {4'h0, r.timing[7:0]};
                    end
                end
            end
            default: n.conv = CV_IDLE;
        endcase

        // I2C target: pointer byte selects a result byte; bit 7 of it clears the alert
        if (i2c_start) begin
            n.i2c = I2_ADDR;
            n.bitcnt = 4'h0;
            n.sda_low = 1'b0;
        end else if (i2c_stop) begin
            n.i2c = I2_IDLE;
            n.sda_low = 1'b0;
        end else if (scl_rise) begin
            if (r.i2c == I2_ADDR || r.i2c == I2_WRITE) begin
                n.shreg = {r.shreg[6:0], r.sda_s[1]};
                n.bitcnt = r.bitcnt + 4'h1;
            end else if (r.i2c == I2_ACK_READ) begin
                n.nack = r.sda_s[1];
            end
        end else if (scl_fall) begin
            case (r.i2c)
                I2_ADDR: begin
                    if (r.bitcnt == 4'h8) begin
                        if (r.shreg[7:1] == I2C_ADDR) begin
                            n.i2c = I2_ACK_ADDR;
                            n.rnw = r.shreg[0];
                            n.sda_low = 1'b1;
                        end else begin
                            n.i2c = I2_IDLE;
                        end
                    end
                end
                I2_ACK_ADDR, I2_ACK_READ: begin
                    n.bitcnt = 4'h0;
                    n.sda_low = 1'b0;
                    if (r.i2c == I2_ACK_READ && r.nack) begin
                        n.i2c = I2_IDLE;
                    end else if (r.i2c == I2_ACK_READ || r.rnw) begin
                        n.ptr = (r.i2c == I2_ACK_READ) ? r.ptr + 2'h1 : r.ptr;
                        n.shreg = result_byte(n.ptr, r.data_bb, r.data_ir);
                        n.sda_low = !n.shreg[7];
                        n.bitcnt = 4'h1;
                        n.i2c = I2_READ;
                    end else begin
                        n.first_byte = 1'b1;
                        n.i2c = I2_WRITE;
                    end
                end
                I2_WRITE: begin
                    if (r.bitcnt == 4'h8) begin
                        n.i2c = I2_ACK_WRITE;
                        n.sda_low = 1'b1;
                        if (r.first_byte) begin
                            n.ptr = r.shreg[1:0];
                            i2c_clear = r.shreg[I2C_CMD_CLEAR_BIT];
                        end
                        n.first_byte = 1'b0;
                    end
                end
                I2_ACK_WRITE: begin
                    n.sda_low = 1'b0;
                    n.bitcnt = 4'h0;
                    n.i2c = I2_WRITE;
                end
                I2_READ: begin
                    if (r.bitcnt == 4'h8) begin
                        n.sda_low = 1'b0;
                        n.i2c = I2_ACK_READ;
                    end else begin
                        n.sda_low = !r.shreg[6];
                        n.shreg = {r.shreg[6:0], 1'b0};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end
                end
                default: n.i2c = I2_IDLE;
            endcase
        end

        // AHB-Lite data phase; reads take one wait state so a preceding write is visible
        if (r.ahb_write) begin
            case (r.ahb_addr)
                OFS_CTRL: n.ctrl = hwdata[CTRL_W-1:0];
                OFS_TIMING: n.timing = hwdata[15:0];
                OFS_THRESH: begin
                    n.th_low = hwdata[15:0];
                    n.th_high = hwdata[31:16];
                end
                OFS_PERSIST: n.persist = hwdata[3:0];
                OFS_IRQ_STATUS: w1c = hwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: n.irq_mask = hwdata[IRQ_W-1:0];
                default: n.hrdata = r.hrdata;
            endcase
        end
        if (r.ahb_read) begin
            case (r.ahb_addr)
                OFS_CTRL: n.hrdata = {28'h000_0000, r.ctrl};
                OFS_TIMING: n.hrdata = {16'h0000, r.timing};
                OFS_THRESH: n.hrdata = {r.th_high, r.th_low};
                OFS_PERSIST: n.hrdata = {28'h000_0000, r.persist};
                OFS_DATA: n.hrdata = {r.data_ir, r.data_bb};
                OFS_IRQ_STATUS: n.hrdata = {30'h0000_0000, r.irq_status};
                OFS_IRQ_MASK: n.hrdata = {30'h0000_0000, r.irq_mask};
                OFS_STATE: n.hrdata = {21'h00_0000, alert_oe, r.alert_s[1], r.i2c, r.pcount, r.conv};
                default: n.hrdata = 32'h0000_0000;
            endcase
        end
        n.ahb_write = accept && hwrite && hsize == HSIZE_WORD;
        n.ahb_read = accept && !hwrite;
        n.ahb_addr = accept ? haddr[7:0] : r.ahb_addr;

        // Sticky events; a new event beats a clear in the same cycle
        w1c[IRQ_ALERT_BIT] = w1c[IRQ_ALERT_BIT] | i2c_clear;
        n.irq_status = (r.irq_status & ~w1c)
            | {cyc_done, cyc_done && trig};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.conv <= CV_IDLE;
            r.i2c <= I2_IDLE;
            r.ctrl <= CTRL_RESET;
            r.timing <= TIMING_RESET;
            r.th_low <= TH_LOW_RESET;
            r.th_high <= TH_HIGH_RESET;
            r.persist <= PERSIST_RESET;
            r.scl_s <= 3'h7;
            r.sda_s <= 3'h7;
            r.alert_s <= 2'h3;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = !r.ahb_read;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign sda_o = 1'b0;
    assign sda_oe = r.sda_low;
    assign alert_o = 1'b0;
    // Status stays sticky with interrupts off; only the pin is gated
    assign alert_oe = r.ctrl[CTRL_INT_EN_BIT] && r.irq_status[IRQ_ALERT_BIT];
    assign irq = |(r.irq_status & r.irq_mask);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_accum_sat: assert property (r.conv == CV_INTEG && step_tick && !cyc_done && r.ctrl[CTRL_RUN_BIT]
        |=> r.acc_bb >= $past(r.acc_bb) && r.acc_ir >= $past(r.acc_ir))
        else $error("accumulator wrapped");
    a_data_latch: assert property (cyc_done |=> r.data_bb == $past(bb_sum) && r.data_ir == $past(ir_sum))
        else $error("result not latched at cycle end");
    a_alert_hold: assert property (alert_oe && w1c[IRQ_ALERT_BIT] == 1'b0 && !r.ahb_write |=> alert_oe)
        else $error("alert dropped without a clear");
    a_oor_count: assert property (cyc_done && oor && r.pcount != 4'hf |=> r.pcount == $past(r.pcount) + 4'h1)
        else $error("out of range result not counted");
    a_persist_gate: assert property (cyc_done && !trig && !r.irq_status[IRQ_ALERT_BIT]
        ##1 !$past(i2c_clear) |-> !r.irq_status[IRQ_ALERT_BIT])
        else $error("alert before persistence reached");
    a_trig_sets: assert property (cyc_done && trig |=> r.irq_status[IRQ_ALERT_BIT])
        else $error("trigger did not set alert status");
    a_thresh_indep: assert property (r.ahb_write && r.ahb_addr == OFS_THRESH |=> $stable(r.persist))
        else $error("threshold write disturbed persistence");
    a_alert_drive: assert property (alert_oe |-> alert_o == 1'b0)
        else $error("alert pin driven high");
    a_addr_ack: assert property (r.i2c == I2_ACK_ADDR |-> sda_oe)
        else $error("address not acknowledged");
    a_wait_count: assert property (r.conv == CV_WAIT && step_tick && r.steps != 12'h001 && r.ctrl[CTRL_RUN_BIT]
        |=> r.steps == $past(r.steps) - 12'h001)
        else $error("wait step count wrong");
    a_integ_load: assert property (r.conv == CV_IDLE && r.ctrl[CTRL_RUN_BIT]
        |=> r.conv == CV_INTEG && r.steps == STEPS_FULL - {4'h0, $past(r.timing[7:0])})
        else $error("integration step count wrong");
    a_int_off: assert property (!r.ctrl[CTRL_INT_EN_BIT] |-> !alert_oe)
        else $error("alert driven with interrupts off");
    a_inrange_clr: assert property (cyc_done && !oor |=> r.pcount == 4'h0)
        else $error("persistence count not reset");
    a_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    c_cycle_done: cover property (cyc_done ##1 r.conv == CV_WAIT);
    c_alert_rise: cover property ($rose(alert_oe));
    c_i2c_read: cover property (r.i2c == I2_ACK_READ ##[1:200] r.i2c == I2_READ);
    c_ahb_read: cover property (accept && !hwrite ##2 hreadyout);
endmodule : alr_top

// ### shared/alr_pkg.sv
// Constants, register map and state types of the ambient light readout.
// Assumes a 200 MHz core clock; all offsets are byte addresses on AHB-Lite.
package alr_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_TIME_US = 2720;
    localparam int STEP_CYCLES_DOC = (STEP_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam logic [11:0] WAIT_LONG_FACTOR = 12'h00c;
    localparam logic [11:0] STEPS_FULL = 12'h100;
    localparam int I2C_MAX_KHZ = 400;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMING = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_PERSIST = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_STATE = 8'h1c;

    localparam int CTRL_W = 4;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_WAIT_EN_BIT = 1;
    localparam int CTRL_INT_EN_BIT = 2;
    localparam int CTRL_WAIT_LONG_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] TIMING_RESET = 16'hffff;
    localparam logic [15:0] TH_LOW_RESET = 16'h0000;
    localparam logic [15:0] TH_HIGH_RESET = 16'hffff;
    localparam logic [3:0] PERSIST_RESET = 4'h0;

    localparam int IRQ_W = 2;
    localparam int IRQ_ALERT_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;

    localparam int I2C_CMD_CLEAR_BIT = 7;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {CV_IDLE, CV_INTEG, CV_WAIT} alr_conv_t;
    typedef enum logic [2:0] {
        I2_IDLE, I2_ADDR, I2_ACK_ADDR, I2_WRITE, I2_ACK_WRITE, I2_READ, I2_ACK_READ
    } alr_i2c_t;
endpackage : alr_pkg

// ### hdl/alr_step_timer.sv
// Free-running step timer: one-cycle tick every COUNT cycles while run is high.
// Assumes run comes from logic on core_clk.
`timescale 1ns/100ps
module alr_step_timer
    import alr_pkg::*;
#(
    parameter int COUNT = STEP_CYCLES_DOC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    output logic tick
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } alr_timer_t;

    alr_timer_t t_reg;
    alr_timer_t t_next;

    always_comb begin
        t_next = t_reg;
        t_next.tick = 1'b0;
        if (!run) begin
            t_next.cnt = '0;
        end else if (t_reg.cnt == LAST) begin
            t_next.cnt = '0;
            t_next.tick = 1'b1;
        end else begin
            t_next.cnt = t_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign tick = t_reg.tick;
endmodule : alr_step_timer

// ### sim/alr_i2c_host.sv
// Bus controller model: drives SCL and pulls SDA for start, stop and byte transfers.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`timescale 1ns/100ps
module alr_i2c_host (
    output logic scl,
    output logic sda_drive,
    input wire logic sda_wire
);
    // Quarter of the 80 ns link clock period
    localparam int Q = 20;

    initial begin
        scl = 1'b1;
        sda_drive = 1'b0;
    end

    // Also a repeated start; SCL stands high between frames
    task automatic start;
        sda_drive = 1'b0;
        #(Q);
        scl = 1'b1;
        #(Q);
        sda_drive = 1'b1;
        #(Q);
        scl = 1'b0;
        #(Q);
    endtask : start

    // Ninth bit: host pulls SDA when ack_out, else samples target acknowledge
    task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= -1; i--) begin
            sda_drive = (i >= 0) ? !tx[i] : ack_out;
            #(Q);
            scl = 1'b1;
            #(Q);
            if (i >= 0) rx[i] = sda_wire;
            else ack_in = !sda_wire;
            #(Q);
            scl = 1'b0;
            #(Q);
        end
        sda_drive = 1'b0;
    endtask : xfer

    task automatic stop;
        sda_drive = 1'b1;
        #(Q);
        scl = 1'b1;
        #(Q);
        sda_drive = 1'b0;
        #(Q);
    endtask : stop
endmodule : alr_i2c_host

// ### sim/test_ambient_light_readout.sv
// Self-checking bench of the readout: registers, conversion, thresholds, alert, I2C reads.
// Assumes the host model in alr_i2c_host.sv and a step shortened to 20 core cycles.
`timescale 1ns/100ps
module test_ambient_light_readout;
    import alr_pkg::*;
    localparam int STEPS_TB = 20;
    // Arbitrary target address
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    typedef struct {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e;} alr_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [9:0] bb_count = 10'h3ff;
    logic [9:0] ir_count = 10'h005;
    logic hreadyout, hresp, sda_oe, alert_oe, irq, scl, host_sda, ack, dev_sda_o, dev_alert_o;
    logic [31:0] hrdata, q, st;
    logic [7:0] rx;
    logic [7:0] b[4];
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire logic sda_wire = !((sda_oe & !dev_sda_o) | host_sda);
    wire logic alert_wire = !(alert_oe & !dev_alert_o);
    alr_row_t rows[10] = '{
        '{OFS_CTRL, 1'b0, 32'h0000_0000, 32'h0000_0000}, '{OFS_TIMING, 1'b0, 32'h0000_0000, 32'h0000_ffff},
        '{OFS_THRESH, 1'b0, 32'h0000_0000, 32'hffff_0000}, '{OFS_PERSIST, 1'b0, 32'h0000_0000, 32'h0000_0000},
        '{OFS_IRQ_MASK, 1'b0, 32'h0000_0000, 32'h0000_0000}, '{OFS_THRESH, 1'b1, 32'h1234_5678, 32'h1234_5678},
        '{OFS_PERSIST, 1'b1, 32'hffff_ffff, 32'h0000_000f}, '{OFS_THRESH, 1'b0, 32'h0000_0000, 32'h1234_5678},
        '{8'h40, 1'b1, 32'hffff_ffff, 32'h0000_0000}, '{OFS_DATA, 1'b0, 32'h0000_0000, 32'h0000_0000}};
    // Threshold, persistence and expected alert status of one conversion each
    logic [31:0] th[9] = '{32'h07fe_0000, 32'h07fd_0000, 32'hffff_07fe, 32'hffff_07ff, 32'hffff_0000,
        32'h0100_0000, 32'hffff_0000, 32'h0100_0000, 32'h0100_0000};
    logic [31:0] pe[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2};
    logic al[9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    alr_top #(.STEP_CYCLES(STEPS_TB), .I2C_ADDR(DEV_ADDR)) u_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .broadband_channel_count(bb_count),
        .infrared_channel_count(ir_count), .scl_i(scl), .sda_i(sda_wire), .sda_o(dev_sda_o), .sda_oe(sda_oe),
        .alert_i(alert_wire), .alert_o(dev_alert_o), .alert_oe(alert_oe), .irq(irq));
    alr_i2c_host u_host (.scl(scl), .sda_drive(host_sda), .sda_wire(sda_wire));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk

    // Aligns to a rising edge first; waits on hready for both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        if (core_clk !== 1'b1) @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    // Polls until a cycle ends, then clears only its done flag
    task automatic cyc(output logic [31:0] s);
        s = 32'h0000_0000;
        for (int n = 0; n < 3000 && s[IRQ_DONE_BIT] !== 1'b1; n++) ahb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000, s);
        chk("cycle done", 32'h0000_0001, 32'(s[IRQ_DONE_BIT]));
        ahb(1'b1, OFS_IRQ_STATUS, 32'h0000_0002, q);
    endtask : cyc

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        foreach (rows[i]) begin
            if (rows[i].wr) ahb(1'b1, rows[i].a, rows[i].d, q);
            ahb(1'b0, rows[i].a, 32'h0000_0000, q);
            chk("register", rows[i].e, q);
        end
        chk("hresp", 32'h0000_0000, 32'(hresp));
        $display("registers done");
        ahb(1'b1, OFS_TIMING, 32'h0000_fffe, q);
        ahb(1'b1, OFS_CTRL, 32'h0000_0005, q);
        cyc(st);
        foreach (th[i]) begin
            ahb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001, q);
            ahb(1'b1, OFS_THRESH, th[i], q);
            ahb(1'b1, OFS_PERSIST, pe[i], q);
            cyc(st);
            chk("alert status", 32'(al[i]), 32'(st[IRQ_ALERT_BIT]));
        end
        ahb(1'b0, OFS_DATA, 32'h0000_0000, q);
        chk("data", {16'(ir_count) * 16'h0002, 16'(bb_count) * 16'h0002}, q);
        @(negedge core_clk);
        chk("alert pin enable", 32'h0000_0001, 32'(alert_oe));
        chk("alert wire", 32'h0000_0000, 32'(alert_wire));
        $display("thresholds done");
        ahb(1'b1, OFS_CTRL, 32'h0000_0004, q);
        repeat (50) @(negedge core_clk);
        chk("alert held", 32'h0000_0001, 32'(alert_oe));
        ahb(1'b1, OFS_IRQ_MASK, 32'h0000_0001, q);
        @(negedge core_clk);
        chk("irq unmasked", 32'h0000_0001, 32'(irq));
        ahb(1'b1, OFS_IRQ_MASK, 32'h0000_0000, q);
        @(negedge core_clk);
        chk("irq masked", 32'h0000_0000, 32'(irq));
        ahb(1'b1, OFS_IRQ_MASK, 32'h0000_0001, q);
        u_host.start();
        u_host.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0, rx, ack);
        chk("foreign address ack", 32'h0000_0000, 32'(ack));
        u_host.stop();
        u_host.start();
        u_host.xfer({DEV_ADDR, 1'b0}, 1'b0, rx, ack);
        chk("address ack", 32'h0000_0001, 32'(ack));
        u_host.xfer(8'h80, 1'b0, rx, ack);
        u_host.stop();
        @(negedge core_clk);
        chk("alert cleared", 32'h0000_0000, 32'(alert_oe));
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        u_host.start();
        u_host.xfer({DEV_ADDR, 1'b0}, 1'b0, rx, ack);
        u_host.xfer(8'h00, 1'b0, rx, ack);
        u_host.start();
        u_host.xfer({DEV_ADDR, 1'b1}, 1'b0, rx, ack);
        for (int i = 0; i < 4; i++) u_host.xfer(8'hff, i < 3, b[i], ack);
        u_host.stop();
        chk("link data", 32'h000a_07fe, {b[3], b[2], b[1], b[0]});
        $display("link done");
        @(posedge core_clk);
        ahb(1'b1, OFS_CTRL, 32'h0000_0001, q);
        ahb(1'b1, OFS_PERSIST, 32'h0000_0000, q);
        cyc(st);
        @(negedge core_clk);
        chk("alert status disabled", 32'h0000_0001, 32'(st[IRQ_ALERT_BIT]));
        chk("alert released", 32'h0000_0000, 32'(alert_oe));
        chk("irq disabled alert", 32'h0000_0001, 32'(irq));
        ahb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001, q);
        @(negedge core_clk);
        chk("irq after clear", 32'h0000_0000, 32'(irq));
        ahb(1'b1, OFS_TIMING, 32'h0000_ff00, q);
        cyc(st);
        cyc(st);
        ahb(1'b0, OFS_DATA, 32'h0000_0000, q);
        chk("saturated data", 32'h0500_ffff, q);
        ahb(1'b1, OFS_CTRL, 32'h0000_0003, q);
        ahb(1'b1, OFS_TIMING, 32'h0000_fefe, q);
        cyc(st);
        ahb(1'b0, OFS_STATE, 32'h0000_0000, q);
        chk("wait state", 32'h0000_0022, {25'h000_0000, q[10:6], q[1:0]});
        $display("conversion done");
        repeat (60) @(posedge core_clk);
        rst <= 1'b1;
        @(negedge core_clk);
        chk("reset outputs", 32'h0000_0010, {27'h000_0000, hreadyout, hresp, sda_oe, alert_oe, irq});
        @(posedge core_clk);
        rst <= 1'b0;
        ahb(1'b0, OFS_TIMING, 32'h0000_0000, q);
        chk("timing after reset", 32'h0000_ffff, q);
        $display("reset done");
        summarize();
    end
endmodule : test_ambient_light_readout
